//--- rtl/hft_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module hft_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [CW-1:0] ONE        = CW'(1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q, wr_ptr_d;
  logic [AW-1:0]    rd_ptr_q, rd_ptr_d;
  logic [CW-1:0]    count_q, count_d;
  logic             ready_q, ready_d;
  logic             push, pop;

  // ==========================================================================
  // Pointers and flags
  // Ready is registered from the next count, so a full FIFO never claims room.
  always_comb begin
    push     = in_valid && ready_q;
    pop      = out_ready && (count_q != '0);
    wr_ptr_d = push ? AW'(wr_ptr_q + 1'b1) : wr_ptr_q;
    rd_ptr_d = pop  ? AW'(rd_ptr_q + 1'b1) : rd_ptr_q;
    count_d  = count_q;
    if (push && !pop) begin
      count_d = count_q + ONE;
    end else if (pop && !push) begin
      count_d = count_q - ONE;
    end
    ready_d = (count_d != FULL_COUNT);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      ready_q  <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
      ready_q  <= ready_d;
    end
  end

  // ==========================================================================
  // Storage
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk) begin
        if (push && (wr_ptr_q == AW'(i))) begin
          mem_q[i] <= in_data;
        end
      end
    end
  endgenerate

  assign in_ready  = ready_q;
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
endmodule
`default_nettype wire

//--- rtl/hft_frame_tx.sv
// Frame transmit sequencer, modem configuration register and event elapsed timer.
//
// Operation
// R1: Each frame starts with twice the preamble pair count of preamble bytes.
// R2: With pair count zero no preamble is added; host queues its own.
// R3: Source select starts timer on end, start, transmit done or carrier edge.
// R4: With delay set, transmit starts one 1200 baud bit after request, with data.
// R5: With delay clear, transmit starts once data is queued, request ignored.
// R6: With auto-release set, frame end drops request pin and control bit.
// R7: With auto-release clear, request stays until host writes zero.
// R8: Carrier edge select picks falling, rising, either, or no edges.
// R9: Duplex bit loops transmit path back into receiver for self-test.
// R10: Power bit at position zero, reset zero, powers the modem up.
// R11: Timer advances one count every 3.255 microseconds once started; the code counts 65 clocks of 50 ns, 3.25 microseconds.
// R12: Timer saturates at all ones until the next qualifying event.
// R13: Timer held at zero while frame monitor enable is clear.
// R14: Timer is a read-only 16-bit value, reset zero, time since event.
// R15: Frame monitor enable at bit twelve turns on the frame monitor.
// R16: Each qualifying event restarts the timer from zero.
`timescale 1ns/1ns
`default_nettype none
module hft_frame_tx #(
  parameter int BIT_CYCLES = hft_pkg::BIT_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire hft_pkg::hft_reg_req_s reg_req,
  output logic               [15:0]  reg_rdata,
  output logic                       reg_rvalid,
  input  wire logic                  tx_byte_valid,
  input  wire logic           [7:0]  tx_byte_data,
  output logic                       tx_byte_ready,
  output logic                       line_tx_valid,
  output logic                [7:0]  line_tx_data,
  input  wire logic                  line_tx_ready,
  output logic                       line_request_to_send,
  input  wire logic                  carrier_detect,
  input  wire logic                  rx_end_of_message,
  input  wire logic                  rx_start_of_message,
  output logic                       tx_done,
  output logic                       modem_power_on,
  output logic                       modem_duplex,
  output logic                       frame_monitor_enable
);
  localparam int DW = $clog2(BIT_CYCLES + 1);
  localparam int TW = $clog2(hft_pkg::TICK_CYCLES + 1);
  localparam logic [DW-1:0] DELAY_END = DW'(BIT_CYCLES);
  localparam logic [TW-1:0] TICK_END  = TW'(hft_pkg::TICK_CYCLES - 1);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PREAMBLE,
    ST_DATA
  } hft_state_e;

  hft_pkg::hft_cfg_s cfg_q, cfg_d;
  logic              rts_q, rts_d;
  logic [15:0]       rdata_q, rdata_d;
  logic              rvalid_q, rvalid_d;
  hft_state_e        state_q, state_d;
  logic [4:0]        pre_left_q, pre_left_d;
  logic [DW-1:0]     dly_q, dly_d;
  logic              line_valid_q, line_valid_d;
  logic [7:0]        line_data_q, line_data_d;
  logic              done_q, done_d;
  logic              rdy_meta_q, rdy_sync_q;
  logic              cd_meta_q, cd_sync_q, cd_prev_q;
  logic [15:0]       timer_q, timer_d;
  logic              running_q, running_d;
  logic [TW-1:0]     tick_q, tick_d;
  logic              fifo_out_valid;
  logic [7:0]        fifo_out_data;
  logic              fifo_pop;
  logic              fifo_in_ready;
  logic              accept;
  logic              cd_edge;
  logic              event_hit;
  logic              frame_end;

  // ==========================================================================
  // Transmit queue
  hft_fifo #(
    .WIDTH (hft_pkg::FIFO_WIDTH),
    .DEPTH (hft_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (tx_byte_valid),
    .in_data   (tx_byte_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_pop)
  );

  // ==========================================================================
  // Pin synchronisers
  // The line ready and carrier detect come from the analogue side, so each
  // passes two flops before anything looks at it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdy_meta_q <= 1'b0;
      rdy_sync_q <= 1'b0;
      cd_meta_q  <= 1'b0;
      cd_sync_q  <= 1'b0;
      cd_prev_q  <= 1'b0;
    end else begin
      rdy_meta_q <= line_tx_ready;
      rdy_sync_q <= rdy_meta_q;
      cd_meta_q  <= carrier_detect;
      cd_sync_q  <= cd_meta_q;
      cd_prev_q  <= cd_sync_q;
    end
  end

  // ==========================================================================
  // Registers
  always_comb begin
    cfg_d    = cfg_q;
    rts_d    = rts_q;
    rvalid_d = reg_req.rd_en;
    rdata_d  = rdata_q;
    if (frame_end && cfg_q.auto_release_send_request) begin
      rts_d = 1'b0; // [R6]
    end
    if (reg_req.wr_en && (reg_req.addr == hft_pkg::ADDR_CONFIG)) begin
      cfg_d = hft_pkg::hft_cfg_s'(reg_req.wdata);
    end
    // A host write of the request bit is newer than the automatic release.
    if (reg_req.wr_en && (reg_req.addr == hft_pkg::ADDR_MODEM_CTRL)) begin
      rts_d = reg_req.wdata[0]; // [R7]
    end
    if (reg_req.rd_en) begin
      unique case (reg_req.addr)
        hft_pkg::ADDR_CONFIG:      rdata_d = 16'(cfg_q);
        hft_pkg::ADDR_EVENT_TIMER: rdata_d = timer_q; // [R14]
        hft_pkg::ADDR_MODEM_CTRL:  rdata_d = {15'h0000, rts_q};
        default:                   rdata_d = hft_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q    <= hft_pkg::hft_cfg_s'(hft_pkg::CONFIG_RESET); // [R10]
      rts_q    <= 1'b0;
      rdata_q  <= hft_pkg::READ_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      cfg_q    <= cfg_d;
      rts_q    <= rts_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ==========================================================================
  // Frame sequencer
  // A byte leaves when the line shows ready while the slot is valid; the slot
  // then stays empty for a cycle, which costs nothing at 1200 baud.
  always_comb begin
    accept       = line_valid_q && rdy_sync_q;
    state_d      = state_q;
    pre_left_d   = pre_left_q;
    line_valid_d = accept ? 1'b0 : line_valid_q;
    line_data_d  = line_data_q;
    fifo_pop     = 1'b0;
    frame_end    = 1'b0;
    // Request time is counted only while the request is held.
    dly_d = !rts_q ? '0 : ((dly_q == DELAY_END) ? dly_q : DW'(dly_q + 1'b1)); // [R4]
    unique case (state_q)
      ST_IDLE: begin
        // With the delay off the request is not looked at at all.
        if (cfg_q.modem_power_on && fifo_out_valid &&
            (!cfg_q.one_bit_delay_after_request || (dly_q == DELAY_END))) begin // [R4] [R5] [R10]
          pre_left_d = {cfg_q.tx_preamble_pair_count, 1'b0}; // [R1]
          state_d    = (cfg_q.tx_preamble_pair_count == 4'h0) ? ST_DATA : ST_PREAMBLE; // [R2]
        end
      end
      ST_PREAMBLE: begin
        if (!line_valid_q) begin
          line_valid_d = 1'b1;
          line_data_d  = hft_pkg::PREAMBLE_BYTE; // [R1]
          pre_left_d   = pre_left_q - 5'h01;
          if (pre_left_q == 5'h01) begin
            state_d = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (!line_valid_q) begin
          if (fifo_out_valid) begin
            fifo_pop     = 1'b1;
            line_valid_d = 1'b1;
            line_data_d  = fifo_out_data;
          end else begin
            frame_end = 1'b1;
            state_d   = ST_IDLE;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    done_d = frame_end;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q      <= ST_IDLE;
      pre_left_q   <= 5'h00;
      dly_q        <= '0;
      line_valid_q <= 1'b0;
      line_data_q  <= 8'h00;
      done_q       <= 1'b0;
    end else begin
      state_q      <= state_d;
      pre_left_q   <= pre_left_d;
      dly_q        <= dly_d;
      line_valid_q <= line_valid_d;
      line_data_q  <= line_data_d;
      done_q       <= done_d;
    end
  end

  // ==========================================================================
  // Event elapsed timer
  always_comb begin
    unique case (cfg_q.carrier_edge_select)
      hft_pkg::CDSEL_FALLING: cd_edge = cd_prev_q && !cd_sync_q; // [R8]
      hft_pkg::CDSEL_RISING:  cd_edge = !cd_prev_q && cd_sync_q; // [R8]
      hft_pkg::CDSEL_ANY:     cd_edge = cd_prev_q ^ cd_sync_q; // [R8]
      default:                cd_edge = 1'b0; // [R8]
    endcase
    unique case (cfg_q.event_timer_source_select)
      hft_pkg::EVSEL_END_OF_MESSAGE:   event_hit = rx_end_of_message; // [R3]
      hft_pkg::EVSEL_START_OF_MESSAGE: event_hit = rx_start_of_message; // [R3]
      hft_pkg::EVSEL_TX_DONE:          event_hit = frame_end; // [R3]
      default:                         event_hit = cd_edge; // [R3]
    endcase
    timer_d   = timer_q;
    running_d = running_q;
    tick_d    = tick_q;
    if (!cfg_q.frame_monitor_enable) begin
      timer_d   = hft_pkg::TIMER_RESET; // [R13]
      running_d = 1'b0;
      tick_d    = '0;
    end else if (event_hit) begin
      timer_d   = hft_pkg::TIMER_RESET; // [R16]
      running_d = 1'b1;
      tick_d    = '0;
    end else if (running_q) begin
      tick_d = (tick_q == TICK_END) ? '0 : TW'(tick_q + 1'b1); // [R11]
      if ((tick_q == TICK_END) && (timer_q != hft_pkg::TIMER_MAX)) begin
        timer_d = timer_q + 16'h0001; // [R11] [R12]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_q   <= hft_pkg::TIMER_RESET;
      running_q <= 1'b0;
      tick_q    <= '0;
    end else begin
      timer_q   <= timer_d;
      running_q <= running_d;
      tick_q    <= tick_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata            = rdata_q;
  assign reg_rvalid           = rvalid_q;
  assign tx_byte_ready        = fifo_in_ready;
  assign line_tx_valid        = line_valid_q;
  assign line_tx_data         = line_data_q;
  assign line_request_to_send = rts_q;
  assign tx_done              = done_q;
  assign modem_power_on       = cfg_q.modem_power_on; // [R10]
  assign modem_duplex         = cfg_q.modem_duplex; // [R9]
  assign frame_monitor_enable = cfg_q.frame_monitor_enable; // [R15]
endmodule
`default_nettype wire

//--- rtl/hft_pkg.sv
// Shared constants and types for the modem frame transmit, configuration and event timer block.
package hft_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0]  ADDR_CONFIG      = 8'h88;
  localparam logic [7:0]  ADDR_EVENT_TIMER = 8'h89;
  localparam logic [7:0]  ADDR_MODEM_CTRL  = 8'h8b;
  localparam logic [15:0] CONFIG_RESET     = 16'hc430;
  localparam logic [15:0] TIMER_RESET      = 16'h0000;
  localparam logic [15:0] TIMER_MAX        = 16'hffff;
  localparam logic [15:0] READ_ZERO        = 16'h0000;

  // ==========================================================================
  // Configuration register layout, most significant field first
  typedef struct packed {
    logic       monitor_reset_on_gap;
    logic       monitor_reset_on_carrier;
    logic       receive_all_chars;
    logic       frame_monitor_enable;
    logic [3:0] tx_preamble_pair_count;
    logic [1:0] event_timer_source_select;
    logic       one_bit_delay_after_request;
    logic       auto_release_send_request;
    logic [1:0] carrier_edge_select;
    logic       modem_duplex;
    logic       modem_power_on;
  } hft_cfg_s;

  // Event timer sources
  localparam logic [1:0] EVSEL_END_OF_MESSAGE   = 2'h0;
  localparam logic [1:0] EVSEL_START_OF_MESSAGE = 2'h1;
  localparam logic [1:0] EVSEL_TX_DONE          = 2'h2;
  localparam logic [1:0] EVSEL_CARRIER_EDGE     = 2'h3;

  // Carrier edge selections
  localparam logic [1:0] CDSEL_FALLING = 2'h0;
  localparam logic [1:0] CDSEL_RISING  = 2'h1;
  localparam logic [1:0] CDSEL_ANY     = 2'h2;

  // ==========================================================================
  // Framing constants
  localparam logic [7:0] PREAMBLE_BYTE = 8'hff;
  localparam int         FIFO_WIDTH    = 8;
  localparam int         FIFO_DEPTH    = 16;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int CLK_PERIOD_PS   = 50_000;
  localparam int LINE_BAUD       = 1200;
  localparam int BIT_CYCLES      = (CLK_HZ + LINE_BAUD - 1) / LINE_BAUD;
  localparam int TICK_PERIOD_PS  = 3_255_000;
  localparam int TICK_CYCLES     = TICK_PERIOD_PS / CLK_PERIOD_PS;

  // Register access request
  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } hft_reg_req_s;

endpackage

//--- tb/hft_frame_tx_checker.sv
// Port-level assertions for the frame transmit block.
`timescale 1ns/1ns
`default_nettype none
module hft_chk #(
  parameter int BIT_CYCLES = 20
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire hft_pkg::hft_reg_req_s reg_req,
  input wire logic [15:0]           reg_rdata,
  input wire logic                  reg_rvalid,
  input wire logic                  line_tx_valid,
  input wire logic [7:0]            line_tx_data,
  input wire logic                  line_request_to_send,
  input wire logic                  tx_done,
  input wire logic                  modem_power_on,
  input wire logic                  modem_duplex,
  input wire logic                  frame_monitor_enable
);
  // ==========
  // Tracking state; it mirrors host writes so the checks see the live settings.
  hft_pkg::hft_cfg_s cfg_q;
  int                rts_cnt_q;
  int                idx_q;
  logic              busy_q;
  logic              v_q;
  logic              cw;
  logic              rise;
  assign cw = reg_req.wr_en && reg_req.addr == hft_pkg::ADDR_CONFIG;
  assign rise = line_tx_valid && !v_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q <= hft_pkg::hft_cfg_s'(hft_pkg::CONFIG_RESET);
      rts_cnt_q <= 0;
      idx_q <= 0;
      busy_q <= 1'b0;
      v_q <= 1'b0;
    end else begin
      if (cw) cfg_q <= hft_pkg::hft_cfg_s'(reg_req.wdata);
      rts_cnt_q <= line_request_to_send ? rts_cnt_q + 1 : 0;
      idx_q <= tx_done ? 0 : idx_q + int'(rise);
      busy_q <= (busy_q || rise) && !tx_done;
      v_q <= line_tx_valid;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Checks
  property p_rd; reg_req.rd_en |=> reg_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer missing");
  property p_pwr; cw |=> modem_power_on == $past(reg_req.wdata[0]); endproperty
  a_pwr: assert property (p_pwr) else $error("power bit wrong");
  property p_dup; cw |=> modem_duplex == $past(reg_req.wdata[1]); endproperty
  a_dup: assert property (p_dup) else $error("duplex bit wrong");
  property p_mon; cw |=> frame_monitor_enable == $past(reg_req.wdata[12]); endproperty
  a_mon: assert property (p_mon) else $error("monitor bit wrong");
  property p_zero;
    (!frame_monitor_enable) [*2] ##0 (reg_req.rd_en && reg_req.addr == hft_pkg::ADDR_EVENT_TIMER)
      |=> reg_rdata == hft_pkg::TIMER_RESET;
  endproperty
  a_zero: assert property (p_zero) else $error("timer not held at zero");
  property p_pre;
    rise && idx_q < 2 * cfg_q.tx_preamble_pair_count |-> line_tx_data == hft_pkg::PREAMBLE_BYTE;
  endproperty
  a_pre: assert property (p_pre) else $error("preamble byte wrong");
  property p_dly; rise && !busy_q && cfg_q.one_bit_delay_after_request |-> rts_cnt_q >= BIT_CYCLES; endproperty
  a_dly: assert property (p_dly) else $error("frame began early");
  property p_on; rise |-> modem_power_on; endproperty
  a_on: assert property (p_on) else $error("sent while powered down");
  property p_ar; tx_done && cfg_q.auto_release_send_request |-> !line_request_to_send; endproperty
  a_ar: assert property (p_ar) else $error("request not released");
  property p_keep;
    tx_done && !cfg_q.auto_release_send_request && $past(line_request_to_send) |-> line_request_to_send;
  endproperty
  a_keep: assert property (p_keep) else $error("request dropped");
endmodule
bind hft_frame_tx hft_chk #(.BIT_CYCLES(BIT_CYCLES)) u_chk (.*);
`default_nettype wire

//--- tb/hft_line_model.sv
// Modem line and carrier front end model.
`timescale 1ns/1ns
`default_nettype none
module hft_line_model (
  input  wire logic       clk,
  input  wire logic       line_tx_valid,
  input  wire logic [7:0] line_tx_data,
  input  wire logic       slow,
  input  wire logic       cd_in,
  output logic            line_tx_ready,
  output logic            carrier_detect
);
  // ==========
  // A byte counts as taken when valid falls; slow mode stalls ready a few cycles.
  logic [7:0] got[$];
  logic       v_q = 1'b0;
  logic [7:0] d_q = 8'h00;
  int         wait_q = 0;
  initial line_tx_ready = 1'b0;
  initial carrier_detect = 1'b0;
  always @(posedge clk) begin
    if (v_q && !line_tx_valid) got.push_back(d_q);
    v_q <= line_tx_valid;
    d_q <= line_tx_data;
    carrier_detect <= cd_in;
    if (!line_tx_valid) begin
      line_tx_ready <= 1'b0;
      wait_q <= slow ? $urandom_range(6) : 0;
    end else if (wait_q > 0) wait_q <= wait_q - 1;
    else line_tx_ready <= 1'b1;
  end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the frame transmit block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ==========
  // Signals
  localparam int         BC   = 20;
  localparam logic [7:0] CFG  = hft_pkg::ADDR_CONFIG;
  localparam logic [7:0] TMR  = hft_pkg::ADDR_EVENT_TIMER;
  localparam logic [7:0] CTRL = hft_pkg::ADDR_MODEM_CTRL;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  hft_pkg::hft_reg_req_s req = '0;
  hft_pkg::hft_cfg_s     cfg;
  logic [15:0]           rdata;
  logic [15:0]           v;
  logic [15:0]           w;
  logic [7:0]            bdata = 8'h00;
  logic [7:0]            ldata;
  logic [7:0]            exp_q[$];
  logic                  bvalid = 1'b0;
  logic                  end_of_message = 1'b0;
  logic                  start_of_message = 1'b0;
  logic                  slow = 1'b0;
  logic                  cdl = 1'b0;
  logic                  rvalid, bready, lvalid, lready, rts, cd, done, pwr, dup, mon;
  int                    errors = 0;
  int                    checks = 0;
  int                    seed;
  always #25 clk = ~clk;
  hft_frame_tx #(.BIT_CYCLES(BC)) dut (.clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .tx_byte_valid(bvalid), .tx_byte_data(bdata), .tx_byte_ready(bready),
    .line_tx_valid(lvalid), .line_tx_data(ldata), .line_tx_ready(lready), .line_request_to_send(rts),
    .carrier_detect(cd), .rx_end_of_message(end_of_message), .rx_start_of_message(start_of_message), .tx_done(done),
    .modem_power_on(pwr), .modem_duplex(dup), .frame_monitor_enable(mon));
  hft_line_model model (.clk(clk), .line_tx_valid(lvalid), .line_tx_data(ldata), .slow(slow),
    .cd_in(cdl), .line_tx_ready(lready), .carrier_detect(cd));
  // ==========
  // Tasks
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic near(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if ((g >= e - 16'h1 && g <= e + 16'h1) !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge clk);
    req <= '0;
    #1;
    cmp(16'(rvalid), 16'h0001);
    d = rdata;
  endtask
  task automatic push(input logic [7:0] b);
    @(posedge clk);
    bvalid <= 1'b1;
    bdata <= b;
    @(posedge clk);
    while (bready !== 1'b1) @(posedge clk);
    bvalid <= 1'b0;
  endtask
  task automatic frame(input int n, input int dly, input int ar, input int nb);
    logic [7:0] b;
    exp_q = {};
    model.got = {};
    cfg.tx_preamble_pair_count = 4'(n);
    cfg.one_bit_delay_after_request = 1'(dly);
    cfg.auto_release_send_request = 1'(ar);
    cfg.modem_power_on = 1'b0;
    wr(CFG, cfg);
    repeat (2 * n) exp_q.push_back(hft_pkg::PREAMBLE_BYTE);
    for (int i = 0; i < nb; i++) begin
      b = (n == 0 && i < 2) ? hft_pkg::PREAMBLE_BYTE : 8'($urandom);
      exp_q.push_back(b);
      push(b);
    end
    if (nb == 16) begin
      cyc(1);
      cmp(16'(bready), 16'h0000);
    end
    cfg.modem_power_on = 1'b1;
    wr(CFG, cfg);
    if (dly != 0) begin
      cyc(3 * BC);
      cmp(16'(lvalid), 16'h0000);
      wr(CTRL, 16'h0001);
    end
    while (done !== 1'b1) @(posedge clk);
    cyc(3);
    cmp(16'(model.got.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) cmp(16'(model.got[i]), 16'(exp_q[i]));
    rd(CTRL, v);
    cmp(v, 16'(dly != 0 && ar == 0));
    cmp(16'(rts), 16'(dly != 0 && ar == 0));
    if (dly != 0 && ar == 0) wr(CTRL, 16'h0000);
  endtask
  task automatic zero_t;
    cfg.frame_monitor_enable = 1'b0;
    wr(CFG, cfg);
    rd(TMR, v);
    cmp(v, 16'h0000);
    cfg.frame_monitor_enable = 1'b1;
    wr(CFG, cfg);
  endtask
  task automatic fire(input int s);
    @(posedge clk);
    if (s == 0) end_of_message <= 1'b1;
    if (s == 1) start_of_message <= 1'b1;
    if (s == 3) cdl <= ~cdl;
    @(posedge clk);
    end_of_message <= 1'b0;
    start_of_message <= 1'b0;
    if (s == 2) frame(1, 0, 1, 1);
  endtask
  // ==========
  // Main sequence; a saturation run would take millions of cycles, so the ceiling is left out.
  initial begin
    seed = $urandom(70069);
    cfg = hft_pkg::CONFIG_RESET;
    cyc(20);
    rst_n <= 1'b1;
    rd(CFG, v);
    cmp(v, hft_pkg::CONFIG_RESET);
    cmp(16'(pwr), 16'h0000);
    wr(TMR, 16'hffff);
    rd(TMR, v);
    cmp(v, hft_pkg::TIMER_RESET);
    wr(8'h55, 16'(~seed));
    rd(8'h55, v);
    cmp(v, hft_pkg::READ_ZERO);
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 16'($urandom) : ~v;
      wr(CFG, v);
      cyc(1);
      cmp(16'({mon, dup, pwr}), 16'({v[12], v[1], v[0]}));
      rd(CFG, w);
      cmp(w, v);
    end
    cfg.frame_monitor_enable = 1'b1;
    frame(1, 0, 1, 3);
    slow <= 1'b1;
    frame(0, 1, 1, 5);
    frame(int'($urandom_range(15)), 1, 0, 16);
    slow <= 1'b0;
    cfg.carrier_edge_select = hft_pkg::CDSEL_ANY;
    for (int s = 0; s < 4; s++) begin
      cfg.event_timer_source_select = 2'(s);
      for (int f = 0; f < 4; f++) if (f != s) begin
        zero_t();
        fire(f);
        cyc(200);
        rd(TMR, v);
        cmp(v, 16'h0000);
      end
      zero_t();
      fire(s);
      cyc(650);
      rd(TMR, v);
      near(v, 16'd10);
      fire(s);
      cyc(130);
      rd(TMR, v);
      near(v, 16'd2);
    end
    for (int e = 0; e < 4; e++) for (int l = 0; l < 2; l++) begin
      cfg.carrier_edge_select = 2'(e);
      @(posedge clk) cdl <= (l == 1);
      zero_t();
      @(posedge clk) cdl <= (l == 0);
      cyc(650);
      rd(TMR, v);
      if (e == 2 || (e == 1 && l == 0) || (e == 0 && l == 1)) near(v, 16'd10);
      else cmp(v, 16'h0000);
    end
    test_done();
  end
  initial begin
    // A clean run needs about 13,000 cycles, so this leaves ample margin.
    #(40_000 * 50);
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
